// ===== sim/lcd_display_data_buffer_test.sv
// Self-checking bench for the display data store and its panel.
// Assumes one AHB-Lite master here and the panel model beside it.
`timescale 1ns/1ns
`default_nettype none
module lcd_display_data_buffer_test;
   import lcd_buf_pkg::*;
   logic                 i_ref_clk, i_rst_n, i_clk_en, clear, rd_dp;
   ahb_req_t             bus;
   logic [31:0]          hwdata, o_hrdata, w;
   logic                 o_hreadyout, o_hresp;
   logic [SEG_COUNT-1:0] segs;
   logic [COM_COUNT-1:0] coms, seen;
   logic [SEG_COUNT-1:0] lit [COM_COUNT];
   logic [7:0]           shadow [BUF_COUNT];
   logic [31:0]          exp_q [$];
   int                   mismatches, comparisons, cycles, seed;

   lcd_display_data_buffer #(.PHASE_LEN(4)) u_lcd_display_data_buffer (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
      .i_ahb({bus.hsel, bus.haddr, bus.htrans, bus.hwrite, bus.hsize,
              o_hreadyout}),
      .i_hwdata(hwdata), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp), .o_segment_output(segs), .o_common_output(coms));
   lcd_panel_model u_lcd_panel_model (
      .i_ref_clk(i_ref_clk), .i_clear(clear), .i_segment_output(segs),
      .i_common_output(coms), .o_lit(lit), .o_seen(seen));

   task automatic check(input logic [31:0] v, input logic [31:0] e,
                        input string what);
      comparisons++;
      if (v !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, e, v);
      end
   endtask

   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
      @(posedge i_ref_clk);
      bus <= '{1'b1, a, HTRANS_NONSEQ, wr, 3'h2, 1'b1};
      do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
      bus.htrans <= 2'h0;
      hwdata <= wd;
      rd_dp <= !wr;
      do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
      rd_dp <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask

   task automatic show(input int d);
      logic [SEG_COUNT-1:0] e;
      xfer(1'b1, 8'h50, 32'(d));
      xfer(1'b1, 8'h50, 32'h80 | d);
      repeat (20) @(posedge i_ref_clk);
      clear <= 1'b1;
      @(posedge i_ref_clk);
      clear <= 1'b0;
      repeat (400) begin
         @(posedge i_ref_clk);
         i_clk_en <= 1'($random(seed));
      end
      @(posedge i_ref_clk);
      i_clk_en <= 1'b1;
      check(32'(seen), (32'h1 << (d + 1)) - 1, "phases");
      for (int c = 0; c <= d; c++) begin
         for (int n = 0; n < BUF_COUNT; n++) begin
            e[2*n]   = shadow[n][c];
            e[2*n+1] = shadow[n][4+c];
         end
         check(32'(lit[c][31:0]), 32'(e[31:0]), "seg_lo");
         check(32'(lit[c][39:32]), 32'(e[39:32]), "seg_hi");
      end
   endtask

   initial begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk) begin
      if (rd_dp && o_hreadyout === 1'b1) begin
         check(o_hrdata, exp_q.pop_front(), "hrdata");
         check(32'(o_hresp), 32'(HRESP_OKAY), "hresp");
      end
      cycles++;
      if (cycles > 10000) begin
         mismatches++;
         end_of_test();
      end
   end

   initial begin
      seed = 2983;
      {i_rst_n, clear, rd_dp, hwdata, bus} = '0;
      i_clk_en = 1'b1;
      {mismatches, comparisons, cycles} = '0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      for (int n = 0; n < BUF_COUNT; n++) rd(8'(4*n), 32'h0);
      for (int n = 0; n < BUF_COUNT; n++) begin
         w = $random(seed);
         shadow[n] = w[7:0];
         xfer(1'b1, 8'(4*n), w);
      end
      for (int n = 0; n < BUF_COUNT; n++)
         rd(8'(4*n), {24'h0, shadow[n]});
      xfer(1'b1, 8'hfc, 32'hff);
      rd(8'hfc, 32'h0);
      check(32'(coms), 32'h0, "dark");
      for (int d = 0; d < COM_COUNT; d++) show(d);
      rd(8'h50, 32'h83);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      check(32'(coms), 32'h0, "reset_com");
      rd(8'h0c, 32'h0);
      end_of_test();
   end
endmodule // lcd_display_data_buffer_test
`default_nettype wire

// ===== sim/lcd_panel_model.sv
// Segment LCD panel model: latches the pixel row of each common phase.
// Assumes one-hot common outputs and segment outputs on the same edge.
`timescale 1ns/1ns
`default_nettype none
module lcd_panel_model
   import lcd_buf_pkg::*;
(
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_clear,
   input  wire logic [SEG_COUNT-1:0] i_segment_output,
   input  wire logic [COM_COUNT-1:0] i_common_output,
   output logic      [SEG_COUNT-1:0] o_lit [COM_COUNT],
   output logic      [COM_COUNT-1:0] o_seen
);
   always_ff @(posedge i_ref_clk) begin
      if (i_clear) begin
         o_seen <= '0;
      end else begin
         for (int c = 0; c < COM_COUNT; c++) begin
            if (i_common_output[c]) begin
               o_lit[c]  <= i_segment_output;
               o_seen[c] <= 1'b1;
            end
         end
      end
   end
endmodule // lcd_panel_model
`default_nettype wire

// ===== src/lcd_buf_pkg.sv
// Constants and types for the segment LCD display data store.
// Assumes one AHB-Lite slave port on the system clock.
package lcd_buf_pkg;
   localparam int unsigned BUF_COUNT    = 20;
   localparam int unsigned BUF_W        = 8;
   localparam int unsigned SEG_COUNT    = 40;
   localparam int unsigned COM_COUNT    = 4;
   localparam int unsigned ADDR_W       = 8;
   localparam int unsigned IDX_W        = 6;

   // Word index of each register; byte address is four times it
   localparam logic [IDX_W-1:0] BUF_FIRST_IDX = 6'h00;
   localparam logic [IDX_W-1:0] CTRL_IDX      = 6'h14;
   localparam logic [IDX_W-1:0] STAT_IDX      = 6'h15;

   localparam logic [7:0]  BUF_RESET      = 8'h00;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam int unsigned CTRL_ON_BIT    = 7;
   localparam int unsigned STAT_SCAN_LSB  = 8;
   localparam int unsigned PHASE_CYCLES   = 256;

   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic        HRESP_OKAY     = 1'b0;

   typedef enum logic [1:0] {
      DRIVE_STATIC  = 2'h0,
      DRIVE_HALF    = 2'h1,
      DRIVE_THIRD   = 2'h2,
      DRIVE_QUARTER = 2'h3
   } drive_t;

   typedef struct packed {
      logic              hsel;
      logic [ADDR_W-1:0] haddr;
      logic [1:0]        htrans;
      logic              hwrite;
      logic [2:0]        hsize;
      logic              hready;
   } ahb_req_t;
endpackage

// ===== src/lcd_display_data_buffer.sv
// Display data store of a segment LCD driver with an AHB-Lite slave.
// Assumes a single master, word transfers, one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none
module lcd_display_data_buffer
   import lcd_buf_pkg::*;
#(
   parameter int unsigned PHASE_LEN = PHASE_CYCLES
) (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_clk_en,
   input  wire ahb_req_t             i_ahb,
   input  wire logic [31:0]          i_hwdata,
   output logic      [31:0]          o_hrdata,
   output logic                      o_hreadyout,
   output logic                      o_hresp,
   output logic      [SEG_COUNT-1:0] o_segment_output,
   output logic      [COM_COUNT-1:0] o_common_output
);

   logic [BUF_W-1:0] buf_r  [BUF_COUNT];
   logic [BUF_W-1:0] copy_r [BUF_COUNT];
   logic [7:0]       ctrl_r;
   logic [4:0]       scan_r;
   logic [1:0]       phase_r;
   logic [15:0]      tick_r;
   logic             wr_pend_r;
   logic [IDX_W-1:0] wr_idx_r;
   logic [IDX_W-1:0] a_idx;
   logic             a_valid;
   logic             fwd;
   logic [31:0]      rd_nxt;
   logic [7:0]       stored;
   drive_t           drive;
   logic             disp_on;
   logic [15:0]      phase_last;

   assign a_idx   = i_ahb.haddr[ADDR_W-1:2];
   assign a_valid = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
   assign drive   = drive_t'(ctrl_r[1:0]);
   assign disp_on = ctrl_r[CTRL_ON_BIT];
   assign fwd     = wr_pend_r && (wr_idx_r == a_idx);
   assign phase_last = 16'(PHASE_LEN - 1);

   // Value stored at an index, before any pending write lands
   always_comb begin
      stored = 8'h00;
      if (a_idx < IDX_W'(BUF_COUNT)) begin
         stored = buf_r[a_idx[4:0]];
      end else if (a_idx == CTRL_IDX) begin
         stored = ctrl_r;
      end
   end

   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (fwd && (a_idx <= CTRL_IDX)) begin
         rd_nxt = {24'h00_0000, i_hwdata[7:0]};
      end else if (a_idx == STAT_IDX) begin
         rd_nxt[1:0] = phase_r;
         rd_nxt[STAT_SCAN_LSB +: 5] = scan_r;
      end else begin
         rd_nxt = {24'h00_0000, stored};
      end
   end

   // Bus address phase capture
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         wr_pend_r <= 1'b0;
         wr_idx_r  <= 6'h00;
      end else if (i_clk_en) begin
         wr_pend_r <= a_valid && i_ahb.hwrite;
         if (a_valid) begin
            wr_idx_r <= a_idx;
         end
      end
   end

   // Read data register and fixed OKAY answer
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_hrdata    <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp     <= HRESP_OKAY;
      end else if (i_clk_en) begin
         o_hreadyout <= 1'b1;
         o_hresp     <= HRESP_OKAY;
         if (a_valid && !i_ahb.hwrite) begin
            o_hrdata <= rd_nxt;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < BUF_COUNT; g++) begin : g_buf
         always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
               buf_r[g] <= BUF_RESET;
            end else if (i_clk_en && wr_pend_r &&
                         wr_idx_r == IDX_W'(g)) begin
               buf_r[g] <= i_hwdata[7:0];
            end
         end
      end
   endgenerate

   // Control: drive method and display on
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         ctrl_r <= CTRL_RESET;
      end else if (i_clk_en && wr_pend_r && wr_idx_r == CTRL_IDX) begin
         ctrl_r <= i_hwdata[7:0];
      end
   end

   // scanner walks the buffers one per cycle
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         scan_r <= 5'h00;
      end else if (i_clk_en) begin
         if (scan_r == 5'(BUF_COUNT - 1)) begin
            scan_r <= 5'h00;
         end else begin
            scan_r <= scan_r + 5'h01;
         end
      end
   end

   generate
      for (g = 0; g < BUF_COUNT; g++) begin : g_copy
         always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
               copy_r[g] <= BUF_RESET;
            end else if (i_clk_en && scan_r == 5'(g)) begin
               copy_r[g] <= buf_r[g];
            end
         end
      end
   endgenerate

   // phase steps through the commons the duty uses
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         tick_r  <= 16'h0000;
         phase_r <= 2'h0;
      end else if (i_clk_en) begin
         if (phase_r > drive) begin
            tick_r  <= 16'h0000;
            phase_r <= 2'h0;
         end else if (tick_r == phase_last) begin
            tick_r  <= 16'h0000;
            phase_r <= (phase_r == drive) ? 2'h0 : phase_r + 2'h1;
         end else begin
            tick_r <= tick_r + 16'h0001;
         end
      end
   end

   // per pair of segments, pick the phase bit of each nibble
   generate
      for (g = 0; g < BUF_COUNT; g++) begin : g_seg
         always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
               o_segment_output[2*g]   <= 1'b0;
               o_segment_output[2*g+1] <= 1'b0;
            end else if (i_clk_en) begin
               o_segment_output[2*g] <= disp_on && phase_r <= drive &&
                                        copy_r[g][phase_r];
               o_segment_output[2*g+1] <= disp_on && phase_r <= drive &&
                                          copy_r[g][3'(phase_r) + 3'h4];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_common_output <= 4'h0;
      end else if (i_clk_en) begin
         o_common_output <= (disp_on && phase_r <= drive) ?
                            4'(4'h1 << phase_r) : 4'h0;
      end
   end

   // Assertions
   // buffer reset clear
   buf_reset_a: assert property (@(posedge i_ref_clk)
      !$past(i_rst_n) |-> buf_r[3] == 8'h00 && buf_r[19] == 8'h00)
      else $error("buffer not cleared by reset");

   buf_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && wr_pend_r && wr_idx_r < 6'h14 |=>
      buf_r[$past(wr_idx_r[4:0])] == $past(i_hwdata[7:0]))
      else $error("buffer write lost");

   read_back_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && a_valid && !i_ahb.hwrite && !fwd && a_idx < 6'h14
      |=> o_hrdata == {24'h00_0000, $past(buf_r[a_idx[4:0]])})
      else $error("read data differs from stored byte");

   scan_fetch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en |=> copy_r[$past(scan_r)] == $past(buf_r[scan_r]))
      else $error("scanner did not fetch buffer");

   scan_wrap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && scan_r == 5'd19 |=> scan_r == 5'd0)
      else $error("scanner wrap wrong");

   phase_limit_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      i_clk_en && $stable(ctrl_r) && phase_r <= drive |=>
      phase_r <= $past(drive))
      else $error("phase beyond drive method");

   pixel_lit_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && disp_on && phase_r == 2'h0 |=>
      o_segment_output[0] == $past(copy_r[0][0]) &&
      o_segment_output[1] == $past(copy_r[0][4]))
      else $error("pixel does not follow buffer bit");

   display_off_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      i_clk_en && !disp_on |=> o_common_output == 4'h0 &&
      o_segment_output == '0)
      else $error("outputs active while display off");

   common_one_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $onehot0(o_common_output) &&
      (o_common_output[3:1] == 3'h0 || $past(drive) != DRIVE_STATIC ||
       !$past(i_clk_en)))
      else $error("common output wrong for drive method");

   // Bus answer
   bus_okay_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      o_hreadyout && o_hresp == HRESP_OKAY)
      else $error("bus answer not ready okay");

   ctrl_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && wr_pend_r && wr_idx_r == CTRL_IDX |=>
      ctrl_r == $past(i_hwdata[7:0]))
      else $error("control write lost");

   unmapped_write_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      i_clk_en && wr_pend_r && wr_idx_r > STAT_IDX |=>
      $stable(ctrl_r) && $stable(buf_r[0]) && $stable(buf_r[19]))
      else $error("unmapped write changed state");

   freeze_count_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      !i_clk_en |=> $stable(scan_r) && $stable(phase_r) &&
      $stable(tick_r))
      else $error("counters moved while disabled");

   freeze_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_clk_en |=> $stable(o_segment_output) &&
      $stable(o_common_output) && $stable(o_hrdata))
      else $error("outputs moved while disabled");

   scan_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && scan_r < 5'd19 |=> scan_r == $past(scan_r) + 5'd1)
      else $error("scanner step wrong");

   phase_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && tick_r != phase_last && phase_r <= drive |=>
      phase_r == $past(phase_r))
      else $error("phase moved early");

   phase_restart_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      i_clk_en && phase_r > drive |=> phase_r == 2'h0)
      else $error("phase did not restart");

   common_phase_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      i_clk_en && disp_on && phase_r <= drive |=>
      $onehot(o_common_output) && o_common_output[$past(phase_r)])
      else $error("active common differs from phase");

   odd_segment_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && disp_on && phase_r == 2'h1 && drive != DRIVE_STATIC |=>
      o_segment_output[39] == $past(copy_r[19][5]) &&
      o_segment_output[38] == $past(copy_r[19][1]))
      else $error("segment pair mapping wrong");

   read_status_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && a_valid && !i_ahb.hwrite && a_idx == STAT_IDX |=>
      o_hrdata[1:0] == $past(phase_r) && o_hrdata[12:8] == $past(scan_r))
      else $error("status read wrong");

   read_forward_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      i_clk_en && a_valid && !i_ahb.hwrite && fwd && a_idx < 6'h14 |=>
      o_hrdata == {24'h00_0000, $past(i_hwdata[7:0])})
      else $error("forwarded read data wrong");

   read_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && !(a_valid && !i_ahb.hwrite) |=> $stable(o_hrdata))
      else $error("read data changed without read");

   upper_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      o_hrdata[31:13] == 19'h0_0000)
      else $error("upper read bits not zero");

   out_reset_a: assert property (@(posedge i_ref_clk)
      !$past(i_rst_n) |-> o_segment_output == '0 &&
      o_common_output == 4'h0 && copy_r[0] == 8'h00 && ctrl_r == 8'h00)
      else $error("outputs not cleared by reset");

endmodule // lcd_display_data_buffer
`default_nettype wire
